// file: rtl/arfp_pkg.sv
// package of constants and types for the amplifier reset and fault protection block
package arfp_pkg;
  localparam int ClkHz = 20_000_000;
  localparam int ResetMinUs = 100;
  localparam int ReadyMaxMs = 12;
  // reset must be seen low this many cycles to count, rounded down; the sequencer does not use it and resets on one low cycle of resetPin_n
  localparam int ResetMinCycles = (ResetMinUs * (ClkHz / 1_000_000));
  // ready no later than this, rounded down
  localparam int ReadyMaxCycles = (ReadyMaxMs * (ClkHz / 1_000));
  localparam int OcPersistCycles = 4;
  localparam logic [6:0] AddrStrapHigh = 7'h56;
  localparam logic [6:0] AddrStrapLow = 7'h54;
  localparam int NumBridges = 4;
  localparam logic [3:0] BridgesAllOff = 4'h0;
  localparam logic [3:0] BridgesAllOn = 4'hF;
  typedef enum logic [1:0] {ARFP_RESET, ARFP_WAKE, ARFP_RUN} arfp_state_t;
endpackage : arfp_pkg

// file: rtl/arfp_oc_guard_if.sv
// interface between the sequencer and the overload guard
`timescale 1ns/1ps
interface arfp_oc_guard_if;
  logic clear;
  logic [1:0] ocHit;
  logic latched;
  modport seq (output clear, output ocHit, input latched);
  modport guard (input clear, input ocHit, output latched);
endinterface : arfp_oc_guard_if

// file: rtl/arfp_oc_guard.sv
// overload guard: filters overcurrent, latches shutdown until fault clears
`timescale 1ns/1ps
module arfp_oc_guard #(
  parameter int PersistCycles = arfp_pkg::OcPersistCycles
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // link to sequencer
  arfp_oc_guard_if.guard gd
);
  logic [7:0] persistReg, persistNext;
  logic latchReg, latchNext;
  logic anyOc;

  // either load counts; shutdown is for all bridges
  assign anyOc = |gd.ocHit;

  // persist counter and latch next values
  always_comb begin
    persistNext = persistReg;
    latchNext = latchReg;
    if (gd.clear) begin
      persistNext = '0;
      latchNext = 1'b0;
    end else if (anyOc) begin
      if (persistReg < 8'(PersistCycles)) persistNext = persistReg + 8'd1;
      if (persistReg >= 8'(PersistCycles - 1)) latchNext = 1'b1;
    end else begin
      persistNext = '0;
      latchNext = 1'b0; // resume once fault gone
    end
  end

  // register
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      persistReg <= '0;
      latchReg <= 1'b0;
    end else begin
      persistReg <= persistNext;
      latchReg <= latchNext;
    end
  end

  assign gd.latched = latchReg;

  oc_latch_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (!gd.clear && anyOc)[*4] |=> gd.latched) else $error("overcurrent not latched");
  oc_release_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !anyOc |=> !gd.latched) else $error("latch held after fault gone");
endmodule : arfp_oc_guard

// file: rtl/arfp_core.sv
// reset sequencing, address strap and power-stage protection top
`timescale 1ns/1ps
module arfp_core #(
  parameter int ReadyCycles = arfp_pkg::ReadyMaxCycles,
  parameter int OcPersist = arfp_pkg::OcPersistCycles
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // controller pins
  input wire logic resetPin_n,
  input wire logic power_down_n,
  input wire logic addr_strap_pin,
  // analog detectors
  input wire logic [1:0] ocDetect,
  input wire logic overTemp,
  input wire logic tempRecovered,
  input wire logic analogUv,
  input wire logic [1:0] powerStageUv,
  // outputs
  output logic [3:0] bridgeEnable,
  output logic fault_n,
  output logic busReady,
  output logic [6:0] busAddr
);
  arfp_pkg::arfp_state_t stateReg, stateNext;
  logic [31:0] cntReg, cntNext;
  logic [6:0] addrReg, addrNext;
  logic thermReg, thermNext;
  logic porDoneReg, porDoneNext;
  logic anyUv, stop, ready;

  arfp_oc_guard_if gif ();

  // overload guard
  arfp_oc_guard #(.PersistCycles(OcPersist)) uGuard (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .gd(gif.guard)
  );

  assign anyUv = analogUv | (|powerStageUv);
  assign gif.ocHit = ocDetect;
  assign gif.clear = !porDoneReg || stateReg == arfp_pkg::ARFP_RESET;

  //////////////////////////////////////////////////////////////////////////////
  // sequencer: reset pin, wake count, strap capture
  always_comb begin
    stateNext = stateReg;
    cntNext = cntReg;
    addrNext = addrReg;
    porDoneNext = 1'b1;
    unique case (stateReg)
      arfp_pkg::ARFP_RESET: begin
        cntNext = '0;
        // pin released high by controller while power-down is not asserted
        if (resetPin_n && power_down_n) begin
          stateNext = arfp_pkg::ARFP_WAKE;
          addrNext = addr_strap_pin ? arfp_pkg::AddrStrapHigh
                                    : arfp_pkg::AddrStrapLow;
        end
      end
      arfp_pkg::ARFP_WAKE: begin
        cntNext = cntReg + 32'd1;
        if (!resetPin_n) stateNext = arfp_pkg::ARFP_RESET;
        else if (cntReg >= 32'(ReadyCycles - 1)) stateNext = arfp_pkg::ARFP_RUN;
      end
      arfp_pkg::ARFP_RUN: begin
        if (!resetPin_n) stateNext = arfp_pkg::ARFP_RESET;
      end
      // the spare code of the state word falls back to reset
      default: begin
        stateNext = arfp_pkg::ARFP_RESET;
      end
    endcase
  end

  // thermal shutdown with self recovery
  always_comb begin
    thermNext = thermReg;
    if (overTemp) thermNext = 1'b1;
    else if (tempRecovered) thermNext = 1'b0;
  end

  // registers
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      stateReg <= arfp_pkg::ARFP_RESET;
      cntReg <= '0;
      addrReg <= arfp_pkg::AddrStrapLow;
      thermReg <= 1'b0;
      porDoneReg <= 1'b0;
    end else begin
      stateReg <= stateNext;
      cntReg <= cntNext;
      addrReg <= addrNext;
      thermReg <= thermNext;
      porDoneReg <= porDoneNext;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // outputs: all four bridges go off together on any fault
  assign ready = stateReg == arfp_pkg::ARFP_RUN;
  assign stop = gif.latched | thermReg | anyUv | !ready;
  assign bridgeEnable = stop ? arfp_pkg::BridgesAllOff : arfp_pkg::BridgesAllOn;
  assign fault_n = !(thermReg | anyUv);
  assign busReady = ready;
  assign busAddr = addrReg;

  //////////////////////////////////////////////////////////////////////////////
  // checks on the protection paths and the sequencer; an undervoltage acts in the same cycle,
  // a thermal trip acts one edge after its cause, the overload latch after four cycles of overcurrent

  // undervoltage must silence the bridges and pull the fault pin at once
  uv_hiz_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    anyUv |->
    bridgeEnable == arfp_pkg::BridgesAllOff && !fault_n)
    else $error("uv not honoured");

  // a thermal trip is seen on the pins one edge later
  therm_trip_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    overTemp |=>
    !fault_n && bridgeEnable == arfp_pkg::BridgesAllOff)
    else $error("thermal trip missed");

  // shutdown persists while the die has not cooled enough
  therm_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    thermReg && !tempRecovered |=>
    !fault_n)
    else $error("thermal shutdown left early");

  // cooling alone brings the part back, no controller action needed
  therm_recover_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    thermReg && !overTemp && tempRecovered && !anyUv |=>
    fault_n)
    else $error("no thermal recovery");

  // fault pin only tracks thermal and undervoltage, never the overload latch
  fault_release_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !thermReg && !anyUv |->
    fault_n)
    else $error("fault stuck low");

  // a latched overload on either load silences every half-bridge
  oc_all_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    gif.latched |->
    bridgeEnable == arfp_pkg::BridgesAllOff)
    else $error("partial bridge shutdown");

  // half-bridges are never driven in part
  bridge_whole_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    1'b1 |->
    bridgeEnable == arfp_pkg::BridgesAllOff || bridgeEnable == arfp_pkg::BridgesAllOn)
    else $error("bridges split");

  // strap level taken on the edge that leaves reset
  strap_cap_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    stateReg == arfp_pkg::ARFP_RESET && resetPin_n && power_down_n |=>
    busAddr == ($past(addr_strap_pin) ? 7'h56 : 7'h54))
    else $error("bad strap");

  // once taken, the address holds until the next reset
  addr_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    stateReg != arfp_pkg::ARFP_RESET |=>
    $stable(busAddr))
    else $error("address moved");

  // bus opens exactly when the wake count ends
  ready_time_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    stateReg == arfp_pkg::ARFP_WAKE && cntReg == 32'(ReadyCycles - 1) && resetPin_n |=>
    busReady)
    else $error("ready late");

  // the wake count never runs past its limit
  wake_bound_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    stateReg == arfp_pkg::ARFP_WAKE |->
    cntReg < 32'(ReadyCycles))
    else $error("wake count overrun");

  // a reset pin pulse closes the bus on the next edge
  ready_drop_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    busReady && !resetPin_n |=>
    !busReady)
    else $error("bus left open in reset");

  // reset state clears the overload guard
  por_clear_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    stateReg == arfp_pkg::ARFP_RESET |=>
    !gif.latched)
    else $error("guard not cleared");

  // power-down keeps the sequencer parked in reset
  pdn_park_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    stateReg == arfp_pkg::ARFP_RESET && !power_down_n |=>
    stateReg == arfp_pkg::ARFP_RESET)
    else $error("left reset in power-down");

  // no drive until the sequencer has finished waking
  run_gate_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !busReady |->
    bridgeEnable == arfp_pkg::BridgesAllOff)
    else $error("bridges driven before run");

  // main scenarios reached
  run_c: cover property (@(posedge clk_sys) disable iff (!rst_n) $rose(busReady));
  oc_c: cover property (@(posedge clk_sys) disable iff (!rst_n) $rose(gif.latched));
  therm_c: cover property (@(posedge clk_sys) disable iff (!rst_n) $fell(thermReg));
  uv_c: cover property (@(posedge clk_sys) disable iff (!rst_n) $rose(anyUv));
  strap_c: cover property (@(posedge clk_sys) disable iff (!rst_n)
    $rose(busReady) && busAddr == arfp_pkg::AddrStrapHigh);
endmodule : arfp_core

// file: dv/arfp_ctrl_model.sv
// system controller model driving the reset and power-down pins
`timescale 1ns/1ps
module arfp_ctrl_model #(
  parameter int HoldCycles = 2000
) (
  // clock
  input wire logic clk_sys,
  // requests from the bench
  input wire logic resetReq,
  input wire logic sleepReq,
  // controller pins
  output logic resetPin_n,
  output logic power_down_n
);
  int cnt;
  logic resetSeen, sleepSeen;
  // pins start in reset, counter armed
  initial begin
    resetPin_n = 1'h0;
    power_down_n = 1'h1;
    cnt = HoldCycles;
    resetSeen = 1'h0;
    sleepSeen = 1'h0;
  end
  // requests taken at the rising edge so the bench's falling-edge writes never race the pins
  always @(posedge clk_sys) begin
    resetSeen <= resetReq;
    sleepSeen <= sleepReq;
    if (resetReq || sleepReq || !power_down_n) cnt <= HoldCycles;
    else if (cnt != 0) cnt <= cnt - 1;
  end
  // pins change only at the falling edge
  always @(negedge clk_sys) begin
    power_down_n <= !sleepSeen;
    resetPin_n <= (cnt == 0) && !resetSeen;
  end
endmodule : arfp_ctrl_model

// file: dv/arfp_core_bench.sv
// self-checking bench for the reset sequencer and power-stage protection
`timescale 1ns/1ps
module arfp_core_bench;
  localparam int Ready = 20;
  logic clk_sys, rst_n, resetReq, sleepReq, addr_strap_pin, overTemp, tempRecovered, analogUv;
  logic resetPin_n, power_down_n, fault_n, busReady;
  logic [1:0] ocDetect, powerStageUv;
  logic [3:0] bridgeEnable;
  logic [6:0] busAddr;
  int fails, checks;
  typedef struct {logic aUv; logic [1:0] pUv; logic [3:0] br; logic flt;} arfp_row_t;
  arfp_row_t rows[4] = '{'{1'h1, 2'h0, 4'h0, 1'h0}, '{1'h0, 2'h1, 4'h0, 1'h0},
                        '{1'h0, 2'h2, 4'h0, 1'h0}, '{1'h0, 2'h0, 4'hF, 1'h1}};
  arfp_ctrl_model #(.HoldCycles(2000)) u_arfp_ctrl_model (.clk_sys(clk_sys),
    .resetReq(resetReq), .sleepReq(sleepReq), .resetPin_n(resetPin_n),
    .power_down_n(power_down_n));
  arfp_core #(.ReadyCycles(Ready), .OcPersist(4)) u_arfp_core (.clk_sys(clk_sys), .rst_n(rst_n),
    .resetPin_n(resetPin_n), .power_down_n(power_down_n), .addr_strap_pin(addr_strap_pin),
    .ocDetect(ocDetect), .overTemp(overTemp), .tempRecovered(tempRecovered),
    .analogUv(analogUv), .powerStageUv(powerStageUv), .bridgeEnable(bridgeEnable),
    .fault_n(fault_n), .busReady(busReady), .busAddr(busAddr));
  // 20 MHz clock
  initial begin
    clk_sys = 1'h0;
    forever #25 clk_sys = ~clk_sys;
  end
  task automatic chk(input logic [6:0] seen, input logic [6:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic conclude();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : conclude
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask : cyc
  // controller reset, then bus readiness and strap address
  task automatic boot(input logic strap);
    addr_strap_pin = strap;
    resetReq = 1'h1;
    cyc(2);
    resetReq = 1'h0;
    @(posedge resetPin_n);
    cyc(1);
    chk(busReady, 1'h0);
    cyc(Ready + 1);
    chk(busReady, 1'h1);
    chk(busAddr, strap ? 7'h56 : 7'h54);
    chk(bridgeEnable, 4'hF);
    $display("test done: boot");
  endtask : boot
  // hang guard
  initial begin
    #2_000_000;
    fails++;
    conclude();
  end
  // main sequence
  initial begin
    {rst_n, resetReq, sleepReq, addr_strap_pin, overTemp, tempRecovered, analogUv} = '0;
    ocDetect = 2'h0;
    powerStageUv = 2'h0;
    cyc(4);
    chk(busReady, 1'h0);
    chk(bridgeEnable, 4'h0);
    $display("test done: reset");
    rst_n = 1'h1;
    boot(1'h0);
    foreach (rows[i]) begin
      analogUv = rows[i].aUv;
      powerStageUv = rows[i].pUv;
      #1;
      chk(bridgeEnable, rows[i].br);
      chk(fault_n, rows[i].flt);
      cyc(1);
    end
    $display("test done: undervoltage rows");
    overTemp = 1'h1;
    cyc(1);
    chk(fault_n, 1'h0);
    chk(bridgeEnable, 4'h0);
    overTemp = 1'h0;
    cyc(2);
    chk(fault_n, 1'h0);
    tempRecovered = 1'h1;
    cyc(2);
    chk(fault_n, 1'h1);
    chk(bridgeEnable, 4'hF);
    tempRecovered = 1'h0;
    $display("test done: thermal");
    ocDetect = 2'h2;
    cyc(3);
    ocDetect = 2'h0;
    cyc(1);
    chk(bridgeEnable, 4'hF);
    ocDetect = 2'h1;
    cyc(5);
    chk(bridgeEnable, 4'h0);
    chk(fault_n, 1'h1);
    ocDetect = 2'h0;
    cyc(2);
    chk(bridgeEnable, 4'hF);
    $display("test done: overcurrent");
    sleepReq = 1'h1;
    cyc(3);
    chk(busReady, 1'h0);
    chk(bridgeEnable, 4'h0);
    sleepReq = 1'h0;
    boot(1'h1);
    // power-on reset again in mid-run, controller pins left high
    rst_n = 1'h0;
    #1;
    chk(busAddr, 7'h54);
    chk(bridgeEnable, 4'h0);
    cyc(1);
    rst_n = 1'h1;
    cyc(2);
    chk(busAddr, 7'h56);
    chk(busReady, 1'h0);
    $display("test done: mid-run reset");
    conclude();
  end
endmodule : arfp_core_bench
